// [hw/lws_regs.svh]
/*
 * Register indices, field positions, reset values and timing counts
 * of the panel write sequencer.
 * Assumes an indirect register scheme: an index register picks the
 * register reached through the data port.
 */
`ifndef LWS_REGS_SVH
`define LWS_REGS_SVH

// -----------------------------------------------------------------
// Register indices
// -----------------------------------------------------------------
`define LWS_IDX_COLOR_DEPTH 8'h42
`define LWS_IDX_WAVE_CFG 8'h49

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define LWS_DEPTH_LSB 0
`define LWS_DEPTH_MSB 2
`define LWS_WL_LSB 0
`define LWS_WH_LSB 4
`define LWS_LAG_LSB 8
`define LWS_LAG_MSB 9

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define LWS_RST_COLOR_DEPTH 16'h0000
`define LWS_RST_WAVE_CFG 16'h0011
`define LWS_RST_INDEX 8'h00

// -----------------------------------------------------------------
// Codes and timing
// -----------------------------------------------------------------
`define LWS_DEPTH_PAIR 3'h2
`define LWS_DEPTH_SINGLE 3'h3
`define LWS_DEPTH_TRIPLE_A 3'h5
`define LWS_DEPTH_TRIPLE_B 3'h6
`define LWS_LAG_NONE 2'h0
`define LWS_LAG_FINE 2'h1
`define LWS_LAG_CYCLE 2'h2
`define LWS_LAG_BOTH 2'h3
`define LWS_CLK_PERIOD_NS 20
`define LWS_LAG_FINE_NS 10
`define LWS_LAG_FINE_CYC \
	((`LWS_LAG_FINE_NS + `LWS_CLK_PERIOD_NS - 1) / `LWS_CLK_PERIOD_NS)

`endif

// [hw/lws_pkg.sv]
/*
 * Types of the panel write sequencer.
 * Assumes lws_regs.svh for register and timing constants.
 */
package lws_pkg;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_LOW = 5'h04,
		ST_HIGH = 5'h08,
		ST_REST = 5'h10
	} lws_state_e;

	// One queued panel word
	typedef struct packed {
		logic cmd;
		logic [15:0] data;
	} lws_word_s;

	// Panel control pins
	typedef struct packed {
		logic selN;
		logic wrN;
		logic rdN;
		logic rs;
	} lws_pins_s;

endpackage

// [hw/lws_fifo.sv]
/*
 * Small show-ahead FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module lws_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("lws_fifo: DEPTH must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic push, pop;

	assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_r != rdPtr_r;
	assign outData = mem[rdPtr_r[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		wrPtr_nxt = wrPtr_r + (AW+1)'(push);
		rdPtr_nxt = rdPtr_r + (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr_r[AW-1:0]] <= inData;
	end

	property p_fifo_bound;
		@(posedge clk) disable iff (!rst_n)
		(wrPtr_r - rdPtr_r) <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound)
		else $error("fifo holds more than its depth");

endmodule

// [hw/lws_write_seq.sv]
/*
 * Panel write sequencer: direct host pass-through to the panel and
 * internally timed pixel/command strobes fed from a word FIFO.
 * Assumes all inputs synchronous to clk (50 MHz) and an indirect
 * register port (index at A1=0, data at A1=1, with A2 high).
 */
// Summary of operation
// - Host A2 low during access passes host strobes to panel strobes
// - In direct access, host A1 drives panel register select
// - Direct access: host writes reach panel bus; reads return panel bus
// - Three-bit colour depth at index 42h picks the transfer format
// - Depth code sets strobes and pixels per sequence
// - Sequence length fixed by depth code, strobe widths and lag
// - Code 2 alone adds a rest of abs(low-high) cycles
// - Strobe low and high widths come from index 49h
// - With lag 00, select and data change on falling strobe
// - Lag field delays the strobe after select and data
// - Transfer-type flag picks command or pixel waveform
`timescale 1ns/100ps
`include "lws_regs.svh"
module lws_write_seq #(
	parameter int WBITS = 4,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host bus
	input wire logic hostSelectN,
	input wire logic hostWriteN,
	input wire logic hostReadN,
	input wire logic hostAddrBit2,
	input wire logic hostAddrBit1,
	input wire logic [15:0] hostDataIn,
	output logic [15:0] hostDataOut,
	output logic hostDataOe,
	// Word stream
	input wire logic wordValid,
	input wire lws_pkg::lws_word_s wordIn,
	output logic wordReady,
	// Panel pins
	output logic panelSelectN,
	output logic panelWriteStrobeN,
	output logic panelReadStrobeN,
	output logic panelRegSelect,
	output logic [15:0] panelDataOut,
	output logic panelDataOe,
	input wire logic [15:0] panelDataIn
);
	initial begin
		if (WBITS < 1 || WBITS > 4)
			$error("lws_write_seq: WBITS must be 1 to 4");
	end

	// -----------------------------------------------------------------
	// Word FIFO
	// -----------------------------------------------------------------
	localparam int FIFO_AW = $clog2(FIFO_DEPTH);

	lws_pkg::lws_word_s fifoWord;
	logic fifoValid, pop, wReady_r, wReady_nxt;
	logic [FIFO_AW:0] occ_r, occ_nxt;

	lws_fifo #(.WIDTH(17), .DEPTH(FIFO_DEPTH)) uFifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(wordValid && wReady_r),
		.inData(wordIn),
		.inReady(),
		.outValid(fifoValid),
		.outData(fifoWord),
		.outReady(pop)
	);

	// Occupancy mirror keeps wordReady a plain flop
	always_comb begin
		occ_nxt = occ_r;
		if (wordValid && wReady_r)
			occ_nxt = occ_nxt + 1'b1;
		if (pop)
			occ_nxt = occ_nxt - 1'b1;
		wReady_nxt = occ_nxt != (FIFO_AW + 1)'(FIFO_DEPTH);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			occ_r <= '0;
			wReady_r <= 1'b0;
		end else begin
			occ_r <= occ_nxt;
			wReady_r <= wReady_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Host register port
	// -----------------------------------------------------------------
	logic [7:0] index_r, index_nxt;
	logic [15:0] depthReg_r, depthReg_nxt, waveReg_r, waveReg_nxt;
	logic hostWrPrev_r, hostSelPrev_r, hostA2Prev_r, hostA1Prev_r;
	logic [15:0] hostDataPrev_r;
	logic regWrite, dirAcc;
	logic [2:0] depth;
	logic [WBITS-1:0] wl, wh;
	logic [1:0] lag;

	assign dirAcc = !hostAddrBit2 && !hostSelectN;
	assign regWrite = !hostWrPrev_r && hostWriteN && !hostSelPrev_r
		&& hostA2Prev_r;
	assign depth = depthReg_r[`LWS_DEPTH_MSB:`LWS_DEPTH_LSB];
	assign wl = waveReg_r[`LWS_WL_LSB +: WBITS];
	assign wh = waveReg_r[`LWS_WH_LSB +: WBITS];
	assign lag = waveReg_r[`LWS_LAG_MSB:`LWS_LAG_LSB];

	always_comb begin
		index_nxt = index_r;
		depthReg_nxt = depthReg_r;
		waveReg_nxt = waveReg_r;
		if (regWrite && !hostA1Prev_r) begin
			index_nxt = hostDataPrev_r[7:0];
		end else if (regWrite && index_r == `LWS_IDX_COLOR_DEPTH) begin
			depthReg_nxt = {13'h0000, hostDataPrev_r[2:0]};
		end else if (regWrite && index_r == `LWS_IDX_WAVE_CFG) begin
			waveReg_nxt = {6'h00, hostDataPrev_r[9:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			index_r <= `LWS_RST_INDEX;
			depthReg_r <= `LWS_RST_COLOR_DEPTH;
			waveReg_r <= `LWS_RST_WAVE_CFG;
			hostWrPrev_r <= 1'b1;
			hostSelPrev_r <= 1'b1;
			hostA2Prev_r <= 1'b1;
			hostA1Prev_r <= 1'b0;
			hostDataPrev_r <= 16'h0000;
		end else begin
			index_r <= index_nxt;
			depthReg_r <= depthReg_nxt;
			waveReg_r <= waveReg_nxt;
			hostWrPrev_r <= hostWriteN;
			hostSelPrev_r <= hostSelectN;
			hostA2Prev_r <= hostAddrBit2;
			hostA1Prev_r <= hostAddrBit1;
			hostDataPrev_r <= hostDataIn;
		end
	end

	// -----------------------------------------------------------------
	// Format decode
	// -----------------------------------------------------------------
	logic [1:0] nStrobes, lagCyc;
	logic [WBITS-1:0] restCyc;

	always_comb begin
		case (depth)
			`LWS_DEPTH_PAIR: nStrobes = 2'h3;
			`LWS_DEPTH_SINGLE: nStrobes = 2'h1;
			`LWS_DEPTH_TRIPLE_A: nStrobes = 2'h3;
			`LWS_DEPTH_TRIPLE_B: nStrobes = 2'h3;
			default: nStrobes = 2'h2;
		endcase
		// Rest makes code 2 span (WL+WH+max+3)*2 cycles
		if (depth != `LWS_DEPTH_PAIR)
			restCyc = '0;
		else if (wl > wh)
			restCyc = wl - wh;
		else
			restCyc = wh - wl;
		case (lag)
			`LWS_LAG_FINE: lagCyc = 2'(`LWS_LAG_FINE_CYC);
			`LWS_LAG_CYCLE: lagCyc = 2'h1;
			`LWS_LAG_BOTH: lagCyc = 2'(1 + `LWS_LAG_FINE_CYC);
			default: lagCyc = 2'h0;
		endcase
	end

	// -----------------------------------------------------------------
	// Sequencer
	// -----------------------------------------------------------------
	lws_pkg::lws_state_e state_r, state_nxt;
	logic [WBITS-1:0] cnt_r, cnt_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic [15:0] seqData_r, seqData_nxt;
	logic cmd_r, cmd_nxt, lastStrobe, startOk;

	assign startOk = fifoValid && !dirAcc;
	assign lastStrobe = cmd_r || idx_r == nStrobes - 2'h1;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		idx_nxt = idx_r;
		seqData_nxt = seqData_r;
		cmd_nxt = cmd_r;
		pop = 1'b0;
		// Every count runs on clk; low and high phases last width+1, setup lasts lagCyc and rest restCyc
		case (state_r)
			lws_pkg::ST_SETUP: begin
				if (cnt_r == '0) begin
					state_nxt = lws_pkg::ST_LOW;
					cnt_nxt = wl;
				end else
					cnt_nxt = cnt_r - 1'b1;
			end
			lws_pkg::ST_LOW: begin
				if (cnt_r == '0) begin
					state_nxt = lws_pkg::ST_HIGH;
					cnt_nxt = wh;
				end else
					cnt_nxt = cnt_r - 1'b1;
			end
			lws_pkg::ST_HIGH: begin
				if (cnt_r != '0)
					cnt_nxt = cnt_r - 1'b1;
				else begin
					idx_nxt = lastStrobe ? 2'h0 : idx_r + 2'h1;
					if (lastStrobe && !cmd_r && restCyc != '0) begin
						state_nxt = lws_pkg::ST_REST;
						cnt_nxt = restCyc - 1'b1;
					end else
						state_nxt = lws_pkg::ST_IDLE;
				end
			end
			lws_pkg::ST_REST: begin
				if (cnt_r == '0)
					state_nxt = lws_pkg::ST_IDLE;
				else
					cnt_nxt = cnt_r - 1'b1;
			end
			default: state_nxt = lws_pkg::ST_IDLE;
		endcase
		// Next word falls in the same edge as the strobe
		if (state_nxt == lws_pkg::ST_IDLE && startOk) begin
			pop = 1'b1;
			seqData_nxt = fifoWord.data;
			cmd_nxt = fifoWord.cmd;
			if (fifoWord.cmd)
				idx_nxt = 2'h0;
			if (lagCyc != 2'h0) begin
				state_nxt = lws_pkg::ST_SETUP;
				cnt_nxt = WBITS'(lagCyc - 2'h1);
			end else begin
				state_nxt = lws_pkg::ST_LOW;
				cnt_nxt = wl;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= lws_pkg::ST_IDLE;
			cnt_r <= '0;
			idx_r <= 2'h0;
			seqData_r <= 16'h0000;
			cmd_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			seqData_r <= seqData_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Pin outputs
	// -----------------------------------------------------------------
	lws_pkg::lws_pins_s pins_r, pins_nxt;
	logic [15:0] pData_r, pData_nxt, hData_r, hData_nxt;
	logic pOe_r, pOe_nxt, hOe_r, hOe_nxt;

	always_comb begin
		pins_nxt = '{selN: 1'b1, wrN: 1'b1, rdN: 1'b1, rs: pins_r.rs};
		pData_nxt = pData_r;
		pOe_nxt = 1'b0;
		hData_nxt = 16'h0000;
		hOe_nxt = 1'b0;
		if (state_nxt != lws_pkg::ST_IDLE) begin
			pins_nxt.selN = 1'b0;
			pins_nxt.wrN = state_nxt != lws_pkg::ST_LOW;
			pins_nxt.rs = !cmd_nxt;
			pData_nxt = seqData_nxt;
			pOe_nxt = 1'b1;
		end else if (dirAcc) begin
			pins_nxt.selN = hostSelectN;
			pins_nxt.wrN = hostWriteN;
			pins_nxt.rdN = hostReadN;
			pins_nxt.rs = hostAddrBit1;
			pData_nxt = hostDataIn;
			pOe_nxt = hostReadN;
		end
		if (dirAcc && !hostReadN) begin
			hData_nxt = panelDataIn;
			hOe_nxt = 1'b1;
		end else if (!hostSelectN && !hostReadN) begin
			hOe_nxt = 1'b1;
			if (!hostAddrBit1)
				hData_nxt = {8'h00, index_r};
			else if (index_r == `LWS_IDX_COLOR_DEPTH)
				hData_nxt = depthReg_r;
			else if (index_r == `LWS_IDX_WAVE_CFG)
				hData_nxt = waveReg_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pins_r <= '{selN: 1'b1, wrN: 1'b1, rdN: 1'b1, rs: 1'b0};
			pData_r <= 16'h0000;
			pOe_r <= 1'b0;
			hData_r <= 16'h0000;
			hOe_r <= 1'b0;
		end else begin
			pins_r <= pins_nxt;
			pData_r <= pData_nxt;
			pOe_r <= pOe_nxt;
			hData_r <= hData_nxt;
			hOe_r <= hOe_nxt;
		end
	end

	// Ready is the mirrored room of the FIFO, one flop
	assign wordReady = wReady_r;
	assign panelSelectN = pins_r.selN;
	assign panelWriteStrobeN = pins_r.wrN;
	assign panelReadStrobeN = pins_r.rdN;
	assign panelRegSelect = pins_r.rs;
	assign panelDataOut = pData_r;
	assign panelDataOe = pOe_r;
	assign hostDataOut = hData_r;
	assign hostDataOe = hOe_r;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	logic [WBITS:0] lowLen_r;
	always_ff @(posedge clk) begin
		if (!rst_n || state_r != lws_pkg::ST_LOW)
			lowLen_r <= '0;
		else
			lowLen_r <= lowLen_r + 1'b1;
	end

	property p_dir_strobe;
		@(posedge clk) disable iff (!rst_n)
		(state_r == lws_pkg::ST_IDLE && dirAcc) |=>
			panelWriteStrobeN == $past(hostWriteN) &&
			panelReadStrobeN == $past(hostReadN);
	endproperty
	a_dir_strobe: assert property (p_dir_strobe)
		else $error("direct strobes not passed through");

	property p_dir_rs;
		@(posedge clk) disable iff (!rst_n)
		(state_r == lws_pkg::ST_IDLE && dirAcc) |=>
			panelRegSelect == $past(hostAddrBit1);
	endproperty
	a_dir_rs: assert property (p_dir_rs)
		else $error("register select does not track host A1");

	property p_dir_data;
		@(posedge clk) disable iff (!rst_n)
		(dirAcc && !hostReadN) |=> hostDataOe &&
			hostDataOut == $past(panelDataIn) && !panelDataOe;
	endproperty
	a_dir_data: assert property (p_dir_data)
		else $error("direct read data not returned");

	property p_low_width;
		@(posedge clk) disable iff (!rst_n)
		(state_r == lws_pkg::ST_LOW && state_nxt == lws_pkg::ST_HIGH)
			|-> lowLen_r == WBITS'(wl);
	endproperty
	a_low_width: assert property (p_low_width)
		else $error("strobe low phase length wrong");

	property p_strobe_count;
		@(posedge clk) disable iff (!rst_n)
		idx_r < nStrobes;
	endproperty
	a_strobe_count: assert property (p_strobe_count)
		else $error("strobe index past sequence length");

	property p_rest_only_pair;
		@(posedge clk) disable iff (!rst_n)
		$rose(state_r == lws_pkg::ST_REST) |->
			depth == `LWS_DEPTH_PAIR && wl != wh;
	endproperty
	a_rest_only_pair: assert property (p_rest_only_pair)
		else $error("rest inserted outside code 2");

	property p_data_on_fall;
		@(posedge clk) disable iff (!rst_n)
		(lag == `LWS_LAG_NONE && $changed(panelDataOut) &&
			state_r != lws_pkg::ST_IDLE && $past(panelDataOe))
			|-> $fell(panelWriteStrobeN);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall)
		else $error("panel data moved away from falling strobe");

	property p_lag_cycle;
		@(posedge clk) disable iff (!rst_n)
		(lag == `LWS_LAG_CYCLE && $rose(state_r == lws_pkg::ST_SETUP))
			|-> panelWriteStrobeN ##1 !panelWriteStrobeN;
	endproperty
	a_lag_cycle: assert property (p_lag_cycle)
		else $error("strobe lag of one cycle not kept");

	property p_idle_quiet;
		@(posedge clk) disable iff (!rst_n)
		(hostAddrBit2 && state_nxt == lws_pkg::ST_IDLE) |=>
			panelWriteStrobeN && panelReadStrobeN && panelSelectN;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("panel strobes active without transfer");

	property p_cmd_rs;
		@(posedge clk) disable iff (!rst_n)
		(state_r == lws_pkg::ST_LOW) |-> panelRegSelect == !cmd_r;
	endproperty
	a_cmd_rs: assert property (p_cmd_rs)
		else $error("register select not set by transfer type");

endmodule

// [verification/lws_panel_model.sv]
/*
 * Behavioural panel controller: answers reads and logs write strobes.
 * Assumes registered, active-low panel strobes from the sequencer.
 */
`timescale 1ns/100ps
module lws_panel_model #(
	parameter logic [15:0] READ_VAL = 16'hA5C3,
	parameter bit SLOW = 1'b0
) (
	// Clock
	input wire logic clk,
	// Panel pins
	input wire logic selN,
	input wire logic wrN,
	input wire logic rdN,
	input wire logic rs,
	input wire logic [15:0] dOut,
	output logic [15:0] dIn
);
	int cyc = 0;
	int since = 0;
	logic wrPrev = 1'b1;
	logic selPrev = 1'b1;
	logic rdSeen = 1'b0;
	logic [16:0] last = '0;
	logic [15:0] drv = 16'h0000;
	int fallCyc[$];
	int fallLag[$];
	logic [16:0] fallWord[$];

	// Released bus shows the inverse of its last value
	assign dIn = (!selN && !rdN && (!SLOW || rdSeen)) ? READ_VAL : ~drv;

	always @(posedge clk) begin
		cyc++;
		if ({rs, dOut} !== last || selPrev)
			since = 0;
		else
			since++;
		if (wrPrev && !wrN) begin
			fallCyc.push_back(cyc);
			fallLag.push_back(since);
			fallWord.push_back({rs, dOut});
		end
		if (!selN && !rdN)
			drv <= dIn;
		rdSeen <= !selN && !rdN;
		wrPrev = wrN;
		selPrev = selN;
		last = {rs, dOut};
	end
endmodule

// [verification/testbench.sv]
/*
 * Self-checking bench of the panel write sequencer.
 * Assumes lws_pkg, lws_regs.svh and the panel model are compiled first.
 */
`timescale 1ns/100ps
`include "lws_regs.svh"
module testbench;
	typedef struct {
		int code;
		int wl;
		int wh;
		int lag;
		int nwrb;
		int rest;
		int lagCyc;
	} lws_row_s;

	logic clk, rst_n, hostSelectN, hostWriteN, hostReadN;
	logic hostAddrBit2, hostAddrBit1, hostDataOe, wordValid, wordReady;
	logic panelSelectN, panelWriteStrobeN, panelReadStrobeN, panelRegSelect;
	logic panelDataOe;
	logic [15:0] hostDataIn, hostDataOut, panelDataOut, panelDataIn;
	lws_pkg::lws_word_s wordIn;
	int n_mismatch = 0;
	int total_checks = 0;
	int base, i, acc;
	lws_row_s rows[12] = '{
		'{0, 1, 1, 0, 2, 0, 0}, '{1, 2, 1, 0, 2, 0, 0},
		'{2, 3, 1, 0, 3, 2, 0}, '{3, 1, 1, 0, 1, 0, 0},
		'{4, 1, 2, 0, 2, 0, 0}, '{5, 2, 2, 0, 3, 0, 0},
		'{6, 1, 3, 0, 3, 0, 0}, '{7, 4, 4, 0, 2, 0, 0},
		'{2, 1, 4, 0, 3, 3, 0}, '{3, 1, 1, 1, 1, 0, 1},
		'{3, 1, 1, 2, 1, 0, 1}, '{3, 1, 1, 3, 1, 0, 2}};

	lws_write_seq uut (.clk(clk), .rst_n(rst_n), .hostSelectN(hostSelectN),
		.hostWriteN(hostWriteN), .hostReadN(hostReadN),
		.hostAddrBit2(hostAddrBit2), .hostAddrBit1(hostAddrBit1),
		.hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
		.hostDataOe(hostDataOe), .wordValid(wordValid), .wordIn(wordIn),
		.wordReady(wordReady), .panelSelectN(panelSelectN),
		.panelWriteStrobeN(panelWriteStrobeN),
		.panelReadStrobeN(panelReadStrobeN), .panelRegSelect(panelRegSelect),
		.panelDataOut(panelDataOut), .panelDataOe(panelDataOe),
		.panelDataIn(panelDataIn));

	lws_panel_model #(.SLOW(1'b1)) panel (.clk(clk), .selN(panelSelectN),
		.wrN(panelWriteStrobeN), .rdN(panelReadStrobeN), .rs(panelRegSelect),
		.dOut(panelDataOut), .dIn(panelDataIn));

	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic hostAcc(input logic a2, input logic a1, input logic wr,
		input logic [15:0] d, input int hold, output logic [16:0] q,
		output logic [20:0] p);
		@(negedge clk);
		hostSelectN = 1'b0;
		hostAddrBit2 = a2;
		hostAddrBit1 = a1;
		hostWriteN = !wr;
		hostReadN = wr;
		hostDataIn = d;
		repeat (hold) @(negedge clk);
		q = {hostDataOe, hostDataOut};
		p = {panelSelectN, panelWriteStrobeN, panelReadStrobeN, panelRegSelect,
			panelDataOe, panelDataOut};
		hostWriteN = 1'b1;
		hostReadN = 1'b1;
		@(negedge clk);
		hostSelectN = 1'b1;
	endtask

	task automatic regWr(input logic [7:0] idx, input logic [15:0] d);
		logic [16:0] q;
		logic [20:0] p;
		hostAcc(1'b1, 1'b0, 1'b1, {8'h00, idx}, 1, q, p);
		hostAcc(1'b1, 1'b1, 1'b1, d, 1, q, p);
	endtask

	task automatic regRd(input logic [7:0] idx, input logic [15:0] exp);
		logic [16:0] q;
		logic [20:0] p;
		hostAcc(1'b1, 1'b0, 1'b1, {8'h00, idx}, 1, q, p);
		hostAcc(1'b1, 1'b1, 1'b0, 16'h0000, 1, q, p);
		check(q, {1'b1, exp});
		check(p[20:18], 3'h7);
	endtask

	task automatic push(input logic cmd, input logic [15:0] d);
		int n;
		logic rdy;
		@(negedge clk);
		wordValid = 1'b1;
		wordIn = {cmd, d};
		rdy = 1'b0;
		for (n = 0; n < 400 && rdy !== 1'b1; n++) begin
			if (n > 0)
				@(negedge clk);
			rdy = wordReady;
			@(posedge clk);
		end
		check(rdy, 1'b1);
	endtask

	task automatic drain(input int n);
		int k;
		@(negedge clk);
		wordValid = 1'b0;
		for (k = 0; k < 2000 && panel.fallCyc.size() < base + n; k++)
			@(negedge clk);
		for (k = 0; k < 100 && panelSelectN !== 1'b1; k++)
			@(negedge clk);
		check(panel.fallCyc.size() >= base + n, 1'b1);
	endtask

	task automatic resetDut();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		check({panelSelectN, panelWriteStrobeN, panelReadStrobeN,
			panelRegSelect, panelDataOe, wordReady}, 6'h38);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
	endtask

	// -------------------------------------------------------------
	// Stimulus
	// -------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("FAIL %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		logic [16:0] q;
		logic [20:0] p;
		rst_n = 1'b0;
		{hostSelectN, hostWriteN, hostReadN, hostAddrBit2} = 4'hF;
		hostAddrBit1 = 1'b0;
		hostDataIn = 16'h0000;
		wordValid = 1'b0;
		wordIn = '0;
		resetDut();
		regRd(`LWS_IDX_COLOR_DEPTH, 16'h0000);
		regRd(`LWS_IDX_WAVE_CFG, 16'h0011);
		regRd(8'h7F, 16'h0000);
		regWr(`LWS_IDX_COLOR_DEPTH, 16'hFFFF);
		regRd(`LWS_IDX_COLOR_DEPTH, 16'h0007);
		$display("register test done");

		foreach (rows[r]) begin
			base = panel.fallCyc.size();
			regWr(`LWS_IDX_COLOR_DEPTH, 16'(rows[r].code));
			regWr(`LWS_IDX_WAVE_CFG, 16'(rows[r].lag << `LWS_LAG_LSB |
				rows[r].wh << `LWS_WH_LSB | rows[r].wl));
			for (i = 0; i < 6; i++)
				push(1'b0, 16'(r * 256 + i * 17 + 1));
			drain(6);
			check(panel.fallLag[base], rows[r].lagCyc);
			for (i = 0; i < 6; i++) begin
				check(panel.fallWord[base + i],
					{1'b1, 16'(r * 256 + i * 17 + 1)});
				if (i > 0 && rows[r].lag == 0)
					check(panel.fallCyc[base + i] - panel.fallCyc[base + i - 1],
						rows[r].wl + rows[r].wh + 2 +
						((i % rows[r].nwrb == 0) ? rows[r].rest : 0));
			end
			$display("row %0d done", r);
		end

		base = panel.fallCyc.size();
		regWr(`LWS_IDX_COLOR_DEPTH, 16'h0003);
		regWr(`LWS_IDX_WAVE_CFG, 16'h0011);
		push(1'b0, 16'h1234);
		push(1'b1, 16'h2C00);
		push(1'b0, 16'h5678);
		drain(3);
		check(panel.fallWord[base + 1], 17'h02C00);
		check(panel.fallWord[base + 2], 17'h15678);
		$display("command test done");

		base = panel.fallCyc.size();
		regWr(`LWS_IDX_WAVE_CFG, 16'h00FF);
		acc = 0;
		for (i = 0; i < 14; i++) begin
			@(negedge clk);
			wordValid = 1'b1;
			wordIn = {1'b0, 16'(acc + 16'h0F00)};
			if (wordReady === 1'b1)
				acc++;
		end
		check(acc, 9);
		drain(9);
		for (i = 0; i < 9; i++)
			check(panel.fallWord[base + i], {1'b1, 16'(i + 16'h0F00)});
		$display("fifo test done");

		hostAcc(1'b0, 1'b1, 1'b1, 16'hBEEF, 1, q, p);
		check(p, {4'h3, 1'b1, 16'hBEEF});
		hostAcc(1'b0, 1'b0, 1'b1, 16'h4321, 1, q, p);
		check(p, {4'h2, 1'b1, 16'h4321});
		hostAcc(1'b0, 1'b0, 1'b0, 16'h0000, 3, q, p);
		check(p[20:18], 3'h2);
		check(q, 17'h1A5C3);
		$display("direct test done");

		push(1'b0, 16'h7777);
		repeat (4) @(negedge clk);
		wordValid = 1'b0;
		resetDut();
		regRd(`LWS_IDX_WAVE_CFG, 16'h0011);
		$display("reset test done");
		end_of_test();
	end
endmodule
